// ===== pkg/usart_pkg.sv
/*
 Shared constants of the synchronous serial channel: register offsets,
 field positions, reset values and the transfer states.
 Assumes an 8-bit register port with a 3-bit word address.
*/
package usart_pkg;
	localparam int ADDR_W = 3;
	localparam int DATA_W = 8;
	localparam logic [2:0] OFS_RSC = 3'h0;
	localparam logic [2:0] OFS_RDB = 3'h1;
	localparam logic [2:0] OFS_TSC = 3'h2;
	localparam logic [2:0] OFS_BAUD = 3'h3;
	localparam logic [2:0] OFS_DIVH = 3'h4;
	localparam logic [2:0] OFS_DIVL = 3'h5;
	localparam logic [2:0] OFS_TDB = 3'h6;
	localparam logic [2:0] OFS_IRQ = 3'h7;
	localparam int RSC_SERIAL_PORT_ENABLE = 7;
	localparam int RSC_RX9 = 6;
	localparam int RSC_SINGLE_RECEIVE_ENABLE = 5;
	localparam int RSC_CONTINUOUS_RECEIVE_ENABLE = 4;
	localparam int RSC_FRAMING_ERROR_FLAG = 2;
	localparam int RSC_OVERRUN_ERROR_FLAG = 1;
	localparam int RSC_RECEIVED_NINTH_BIT = 0;
	localparam int TSC_CLOCK_SOURCE_MASTER_SELECT = 7;
	localparam int TSC_TX9 = 6;
	localparam int TSC_TRANSMIT_ENABLE = 5;
	localparam int TSC_SYNC = 4;
	localparam int TSC_TRMT = 1;
	localparam int TSC_TRANSMIT_NINTH_BIT = 0;
	localparam int BAUD_RCIDL = 6;
	localparam int BAUD_DATA_POLARITY_SELECT = 5;
	localparam int BAUD_CLOCK_POLARITY_SELECT = 4;
	localparam int BAUD_SIXTEEN_BIT_RATE_SELECT = 3;
	localparam int IRQ_RCIE = 0;
	localparam int IRQ_TXIE = 1;
	localparam int IRQ_RCIF = 2;
	localparam int IRQ_TXIF = 3;
	localparam logic [7:0] REG_RST = 8'h00;
	localparam logic [3:0] BITS_8 = 4'h8;
	localparam logic [3:0] BITS_9 = 4'h9;
	typedef enum logic [1:0] {ST_IDLE, ST_TX, ST_RX} xfer_t;
endpackage

// ===== rtl/pin_sync.sv
/*
 Two-flop synchroniser for pins arriving from outside the clock domain.
 Assumes nothing but clk and rst; the first stage is read only by the second.
*/
`timescale 1ns/1ps
module pin_sync #(
	parameter int W = 2
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_reg;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			meta_reg <= '0;
			q <= '0;
		end
		else
		begin
			meta_reg <= d;
			q <= meta_reg;
		end
	end
endmodule

// ===== rtl/rate_gen.sv
/*
 Baud tick generator: one tick every div+1 clocks while run is high.
 Assumes div is steady during a transfer; reload happens while stopped.
*/
`timescale 1ns/1ps
module rate_gen #(
	parameter int W = 16
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic run,
	input wire logic [W-1:0] div,
	output logic tick
);
	logic [W-1:0] cnt_reg;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			cnt_reg <= '0;
			tick <= 1'b0;
		end
		else if (!run || cnt_reg == '0)
		begin
			cnt_reg <= div;
			tick <= run;
		end
		else
		begin
			cnt_reg <= cnt_reg - 1'b1;
			tick <= 1'b0;
		end
	end
endmodule

// ===== rtl/usart_sync.sv
/*
 Synchronous half-duplex serial channel, master and slave, with its registers.
 Assumes a one-cycle register port, pins sampled through pin_sync, and a
 sleep_mode level from the power manager on the same clock.
*/
`timescale 1ns/1ps
module usart_sync
	import usart_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [DATA_W-1:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [DATA_W-1:0] rdata,
	input wire logic sleep_mode,
	input wire logic shift_clock_pin_in,
	output logic shift_clock_pin_out,
	output logic shift_clock_pin_oe,
	input wire logic serial_data_pin_in,
	output logic serial_data_pin_out,
	output logic serial_data_pin_oe,
	output logic rx_irq,
	output logic tx_irq,
	output logic wake_req
);
	logic serial_port_enable_reg, nine_bit_receive_select_reg;
	logic single_receive_enable_reg, continuous_receive_enable_reg;
	logic clock_source_master_select_reg, nine_bit_transmit_select_reg;
	logic transmit_enable_reg, synchronous_select_reg, transmit_ninth_bit_reg;
	logic data_polarity_select_reg, clock_polarity_select_reg, sixteen_bit_rate_select_reg;
	logic [7:0] baud_divisor_high_reg, baud_divisor_low_reg;
	logic receive_interrupt_enable_reg, transmit_interrupt_enable_reg;
	logic [7:0] transmit_data_buffer_reg, receive_data_buffer_reg;
	logic txbuf_full_reg, receive_complete_flag_reg, overrun_error_flag_reg;
	logic received_ninth_bit_reg;
	xfer_t state_reg;
	logic [3:0] bit_cnt_reg;
	logic [8:0] tsr_reg, rsr_reg;
	logic sck_int_reg, sck_prev_reg;
	logic [1:0] pins_s;
	logic tick, sck_lvl, dt_lvl, link_on, master_on;
	logic lead_ev, trail_ev, rx_en, tx_go, last_bit, rx_done, tx_load, abort;
	logic [8:0] rsr_next;
	logic [3:0] tx_bits, rx_bits;
	logic wr_tdb, rd_rdb, transmit_buffer_empty_flag;

	assign wr_tdb = wr && addr == OFS_TDB;
	assign rd_rdb = rd && addr == OFS_RDB;
	assign transmit_buffer_empty_flag = !txbuf_full_reg;
	assign link_on = serial_port_enable_reg && synchronous_select_reg;
	assign master_on = link_on && clock_source_master_select_reg;

	pin_sync #(.W(2)) u_sync (
		.clk(clk),
		.rst(rst),
		.d({shift_clock_pin_in, serial_data_pin_in}),
		.q(pins_s)
	);

	// Pins seen through the polarity selects
	assign sck_lvl = pins_s[1] ^ clock_polarity_select_reg;
	assign dt_lvl = pins_s[0] ^ data_polarity_select_reg;

	// Master clock stops in sleep; a slave keeps shifting on the external clock
	rate_gen #(.W(16)) u_rate (
		.clk(clk),
		.rst(rst),
		.run(master_on && state_reg != ST_IDLE && !sleep_mode),
		.div(sixteen_bit_rate_select_reg ? {baud_divisor_high_reg, baud_divisor_low_reg}
			: {8'h00, baud_divisor_low_reg}),
		.tick(tick)
	);

	// Lead: clock leaves idle; trail: clock returns to idle
	always_comb
	begin
		if (master_on)
		begin
			lead_ev = tick && !sck_int_reg;
			trail_ev = tick && sck_int_reg;
		end
		else
		begin
			lead_ev = link_on && sck_lvl && !sck_prev_reg;
			trail_ev = link_on && !sck_lvl && sck_prev_reg;
		end
	end

	// Single_receive_enable is ignored in slave mode; an overrun holds reception off
	assign rx_en = link_on && !overrun_error_flag_reg && (continuous_receive_enable_reg
		|| (master_on && single_receive_enable_reg));
	assign tx_go = link_on && transmit_enable_reg && txbuf_full_reg && !rx_en;
	assign tx_bits = nine_bit_transmit_select_reg ? BITS_9 : BITS_8;
	assign rx_bits = nine_bit_receive_select_reg ? BITS_9 : BITS_8;
	assign last_bit = bit_cnt_reg == ((state_reg == ST_TX) ? tx_bits : rx_bits) - 4'h1;
	assign rsr_next = {dt_lvl, rsr_reg[8:1]};
	assign abort = !link_on || (state_reg == ST_RX && !rx_en)
		|| (state_reg == ST_TX && !transmit_enable_reg);
	assign rx_done = state_reg == ST_RX && !abort && trail_ev && last_bit;
	// Next word loads only after the last bit of the previous one
	assign tx_load = (state_reg == ST_IDLE && tx_go) || (state_reg == ST_TX && !abort
		&& trail_ev && last_bit && txbuf_full_reg);

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			sck_prev_reg <= 1'b0;
		else
			sck_prev_reg <= sck_lvl;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			sck_int_reg <= 1'b0;
		else if (!master_on || state_reg == ST_IDLE || abort)
			sck_int_reg <= 1'b0;
		else if (tick)
			sck_int_reg <= !sck_int_reg;
	end

	// Shift engine shared by master and slave
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			state_reg <= ST_IDLE;
			bit_cnt_reg <= 4'h0;
			tsr_reg <= '0;
			rsr_reg <= '0;
		end
		else
		begin
			case (state_reg)
				ST_IDLE:
				begin
					bit_cnt_reg <= 4'h0;
					if (rx_en)
						state_reg <= ST_RX;
					else if (tx_load)
					begin
						state_reg <= ST_TX;
						tsr_reg <= {transmit_ninth_bit_reg, transmit_data_buffer_reg};
					end
				end
				ST_TX:
				begin
					if (abort)
					begin
						state_reg <= ST_IDLE;
						bit_cnt_reg <= 4'h0;
					end
					else if (trail_ev && last_bit)
					begin
						bit_cnt_reg <= 4'h0;
						if (tx_load)
							tsr_reg <= {transmit_ninth_bit_reg, transmit_data_buffer_reg};
						else
							state_reg <= ST_IDLE;
					end
					else if (trail_ev)
					begin
						tsr_reg <= {1'b0, tsr_reg[8:1]};
						bit_cnt_reg <= bit_cnt_reg + 4'h1;
					end
				end
				ST_RX:
				begin
					if (abort)
					begin
						state_reg <= ST_IDLE;
						bit_cnt_reg <= 4'h0;
					end
					else if (trail_ev)
					begin
						rsr_reg <= rsr_next;
						bit_cnt_reg <= last_bit ? 4'h0 : bit_cnt_reg + 4'h1;
						// Only continuous mode runs on to the next word
						if (last_bit && !continuous_receive_enable_reg)
							state_reg <= ST_IDLE;
					end
				end
				default:
					state_reg <= ST_IDLE;
			endcase
		end
	end

	// Software-owned control bits, except that a finished single master word clears single_receive_enable_reg
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			serial_port_enable_reg <= REG_RST[RSC_SERIAL_PORT_ENABLE];
			nine_bit_receive_select_reg <= REG_RST[RSC_RX9];
			single_receive_enable_reg <= REG_RST[RSC_SINGLE_RECEIVE_ENABLE];
			continuous_receive_enable_reg <= REG_RST[RSC_CONTINUOUS_RECEIVE_ENABLE];
		end
		else if (wr && addr == OFS_RSC)
		begin
			serial_port_enable_reg <= wdata[RSC_SERIAL_PORT_ENABLE];
			nine_bit_receive_select_reg <= wdata[RSC_RX9];
			single_receive_enable_reg <= wdata[RSC_SINGLE_RECEIVE_ENABLE];
			continuous_receive_enable_reg <= wdata[RSC_CONTINUOUS_RECEIVE_ENABLE];
		end
		else if (rx_done && master_on && !continuous_receive_enable_reg)
			single_receive_enable_reg <= 1'b0;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			clock_source_master_select_reg <= REG_RST[TSC_CLOCK_SOURCE_MASTER_SELECT];
			nine_bit_transmit_select_reg <= REG_RST[TSC_TX9];
			transmit_enable_reg <= REG_RST[TSC_TRANSMIT_ENABLE];
			synchronous_select_reg <= REG_RST[TSC_SYNC];
			transmit_ninth_bit_reg <= REG_RST[TSC_TRANSMIT_NINTH_BIT];
		end
		else if (wr && addr == OFS_TSC)
		begin
			clock_source_master_select_reg <= wdata[TSC_CLOCK_SOURCE_MASTER_SELECT];
			nine_bit_transmit_select_reg <= wdata[TSC_TX9];
			transmit_enable_reg <= wdata[TSC_TRANSMIT_ENABLE];
			synchronous_select_reg <= wdata[TSC_SYNC];
			transmit_ninth_bit_reg <= wdata[TSC_TRANSMIT_NINTH_BIT];
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			data_polarity_select_reg <= REG_RST[BAUD_DATA_POLARITY_SELECT];
			clock_polarity_select_reg <= REG_RST[BAUD_CLOCK_POLARITY_SELECT];
			sixteen_bit_rate_select_reg <= REG_RST[BAUD_SIXTEEN_BIT_RATE_SELECT];
			baud_divisor_high_reg <= REG_RST;
			baud_divisor_low_reg <= REG_RST;
			receive_interrupt_enable_reg <= REG_RST[IRQ_RCIE];
			transmit_interrupt_enable_reg <= REG_RST[IRQ_TXIE];
		end
		else if (wr)
		begin
			case (addr)
				OFS_BAUD:
				begin
					data_polarity_select_reg <= wdata[BAUD_DATA_POLARITY_SELECT];
					clock_polarity_select_reg <= wdata[BAUD_CLOCK_POLARITY_SELECT];
					sixteen_bit_rate_select_reg <= wdata[BAUD_SIXTEEN_BIT_RATE_SELECT];
				end
				OFS_DIVH:
					baud_divisor_high_reg <= wdata;
				OFS_DIVL:
					baud_divisor_low_reg <= wdata;
				OFS_IRQ:
				begin
					receive_interrupt_enable_reg <= wdata[IRQ_RCIE];
					transmit_interrupt_enable_reg <= wdata[IRQ_TXIE];
				end
				default:
					baud_divisor_low_reg <= baud_divisor_low_reg;
			endcase
		end
	end

	// Buffer write beats a same-cycle load, so a fresh word is never lost
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			transmit_data_buffer_reg <= REG_RST;
			txbuf_full_reg <= 1'b0;
		end
		else if (wr_tdb)
		begin
			transmit_data_buffer_reg <= wdata;
			txbuf_full_reg <= 1'b1;
		end
		else if (tx_load)
			txbuf_full_reg <= 1'b0;
	end

	// Receive results; a word finishing while the flag is still up is dropped
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			receive_data_buffer_reg <= REG_RST;
			received_ninth_bit_reg <= 1'b0;
			receive_complete_flag_reg <= 1'b0;
			overrun_error_flag_reg <= 1'b0;
		end
		else
		begin
			if (rx_done && !receive_complete_flag_reg)
			begin
				receive_data_buffer_reg <= nine_bit_receive_select_reg ? rsr_next[7:0] : rsr_next[8:1];
				received_ninth_bit_reg <= nine_bit_receive_select_reg && rsr_next[8];
			end
			if (rx_done)
				receive_complete_flag_reg <= 1'b1;
			else if (rd_rdb)
				receive_complete_flag_reg <= 1'b0;
			if (rx_done && receive_complete_flag_reg)
				overrun_error_flag_reg <= 1'b1;
			else if (!continuous_receive_enable_reg)
				overrun_error_flag_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			rdata <= 8'h00;
		else if (!rd)
			rdata <= 8'h00;
		else
		begin
			case (addr)
				OFS_RSC:
					rdata <= {serial_port_enable_reg, nine_bit_receive_select_reg,
						single_receive_enable_reg, continuous_receive_enable_reg, 2'b00,
						overrun_error_flag_reg, received_ninth_bit_reg};
				OFS_RDB:
					rdata <= receive_data_buffer_reg;
				OFS_TSC:
					rdata <= {clock_source_master_select_reg, nine_bit_transmit_select_reg,
						transmit_enable_reg, synchronous_select_reg, 2'b00,
						state_reg != ST_TX, transmit_ninth_bit_reg};
				OFS_BAUD:
					rdata <= {1'b0, state_reg != ST_RX, data_polarity_select_reg,
						clock_polarity_select_reg, sixteen_bit_rate_select_reg, 3'b000};
				OFS_DIVH:
					rdata <= baud_divisor_high_reg;
				OFS_DIVL:
					rdata <= baud_divisor_low_reg;
				OFS_TDB:
					rdata <= transmit_data_buffer_reg;
				default:
					rdata <= {4'h0, transmit_buffer_empty_flag, receive_complete_flag_reg,
						transmit_interrupt_enable_reg, receive_interrupt_enable_reg};
			endcase
		end
	end

	// Pin drivers; idle levels follow the polarity selects
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			shift_clock_pin_out <= 1'b0;
			shift_clock_pin_oe <= 1'b0;
			serial_data_pin_out <= 1'b0;
			serial_data_pin_oe <= 1'b0;
		end
		else
		begin
			shift_clock_pin_out <= sck_int_reg ^ clock_polarity_select_reg;
			shift_clock_pin_oe <= master_on;
			serial_data_pin_out <= ((state_reg == ST_TX) && tsr_reg[0]) ^ data_polarity_select_reg;
			serial_data_pin_oe <= link_on && state_reg == ST_TX;
		end
	end

	// Vectoring is up to the core's global enable; only the request is made here
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			rx_irq <= 1'b0;
			tx_irq <= 1'b0;
			wake_req <= 1'b0;
		end
		else
		begin
			rx_irq <= receive_complete_flag_reg && receive_interrupt_enable_reg;
			tx_irq <= transmit_buffer_empty_flag && transmit_interrupt_enable_reg;
			wake_req <= sleep_mode && ((receive_complete_flag_reg && receive_interrupt_enable_reg)
				|| (transmit_buffer_empty_flag && transmit_interrupt_enable_reg));
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	sequence s_word_done;
		rx_done && master_on && !continuous_receive_enable_reg;
	endsequence
	sequence s_reload;
		state_reg == ST_TX && tx_load && !wr_tdb;
	endsequence

	rx_start_a: assert property ((state_reg != ST_RX) ##1 (state_reg == ST_RX) |->
		$past(single_receive_enable_reg || continuous_receive_enable_reg))
		else $error("reception began without an enable");
	rx_sample_a: assert property (master_on && state_reg == ST_RX && !abort && tick && sck_int_reg
		|=> rsr_reg[8] == $past(dt_lvl))
		else $error("receive bit not taken at clock return");
	single_stop_a: assert property (s_word_done |=> !single_receive_enable_reg
		&& state_reg == ST_IDLE ##1 !sck_int_reg)
		else $error("single reception did not stop");
	cont_run_a: assert property (rx_done && continuous_receive_enable_reg
		|=> state_reg == ST_RX)
		else $error("continuous reception stopped");
	rcif_set_a: assert property (rx_done |=> receive_complete_flag_reg)
		else $error("receive flag not set");
	irq_gate_a: assert property (rx_irq |-> $past(receive_interrupt_enable_reg))
		else $error("receive interrupt while disabled");
	err_clear_a: assert property (!continuous_receive_enable_reg && !rx_done
		|=> !overrun_error_flag_reg)
		else $error("error flag kept after enable cleared");
	txif_late_a: assert property (s_reload |=> txbuf_full_reg == 1'b0
		&& tsr_reg[7:0] == $past(transmit_data_buffer_reg))
		else $error("second word not moved before flag");
	half_dup_a: assert property (state_reg == ST_RX |=> !serial_data_pin_oe)
		else $error("data driven while receiving");
	clk_idle_a: assert property (master_on && !sck_int_reg |=>
		shift_clock_pin_out == $past(clock_polarity_select_reg))
		else $error("clock idle level wrong");
	slave_clk_a: assert property (!master_on |=> !shift_clock_pin_oe)
		else $error("clock driven in slave mode");
	wake_a: assert property (sleep_mode && transmit_buffer_empty_flag
		&& transmit_interrupt_enable_reg |=> wake_req)
		else $error("no wake on transmit interrupt");
endmodule

// ===== tb/serial_peer.sv
/*
 Far-side partner of the synchronous channel: answers master reception with
 a preset word and acts as clock master for slave transmission.
 Assumes the bench resolves both pins, with a pull-down on each line.
*/
`timescale 1ns/1ps
module serial_peer (
	input wire logic ck_in,
	input wire logic dt_in,
	input wire logic ck_idle,
	input wire logic dt_inv,
	input wire logic respond,
	input wire logic [3:0] bits,
	input wire logic [8:0] tx_word,
	output logic ck_out,
	output logic ck_oe,
	output logic dt_out,
	output logic dt_oe,
	output logic [8:0] rx_word
);
	int idx;
	initial
	begin
		ck_out = 1'b0;
		ck_oe = 1'b0;
		dt_out = 1'b0;
		dt_oe = 1'b0;
		rx_word = 9'h000;
		idx = 0;
	end
	// Next bit goes out on the leading edge, so it stands across the trailing one
	always @(ck_in or respond)
	begin
		dt_oe = respond;
		if (!respond)
			idx = 0;
		else if (ck_in !== ck_idle)
		begin
			dt_out = tx_word[idx] ^ dt_inv;
			idx = (idx + 1) % bits;
		end
	end
	// Clock stands at idle between frames; sampled just before each trail
	task automatic clock_bits(input int n);
		ck_oe = 1'b1;
		ck_out = ck_idle;
		#7;
		repeat (n)
		begin
			#100 ck_out = ~ck_idle;
			#100 rx_word = {dt_in ^ dt_inv, rx_word[8:1]};
			ck_out = ck_idle;
		end
	endtask
endmodule

// ===== tb/tb_top.sv
/*
 Self-checking bench of the synchronous channel: register port tasks,
 master reception, polarity, overrun and slave transmission across sleep.
 Assumes serial_peer on the pins; undriven lines are pulled down.
*/
`timescale 1ns/1ps
module tb_top;
	import usart_pkg::*;
	logic clk, rst, wr, rd, sleep_mode, ck_idle, dt_inv, respond;
	logic [2:0] addr;
	logic [7:0] wdata, rdata;
	logic [3:0] bits;
	logic [8:0] tx_word, p_rx;
	logic ck_o, ck_oe, dt_o, dt_oe, p_ck, p_ck_oe, p_dt, p_dt_oe, rx_irq, tx_irq, wake_req;
	logic ck_pin, dt_pin;
	int n_fail = 0;
	int cmp_count = 0;
	int cycles = 0;
	int rise_cnt = 0;
	logic [7:0] rst_val [8] = '{8'h00, 8'h00, 8'h02, 8'h40, 8'h00, 8'h00, 8'h00, 8'h08};
	assign ck_pin = ck_oe ? ck_o : (p_ck_oe ? p_ck : 1'b0);
	assign dt_pin = dt_oe ? dt_o : (p_dt_oe ? p_dt : 1'b0);
	usart_sync dut_u (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.sleep_mode(sleep_mode), .shift_clock_pin_in(ck_pin), .shift_clock_pin_out(ck_o),
		.shift_clock_pin_oe(ck_oe), .serial_data_pin_in(dt_pin), .serial_data_pin_out(dt_o),
		.serial_data_pin_oe(dt_oe), .rx_irq(rx_irq), .tx_irq(tx_irq), .wake_req(wake_req));
	serial_peer peer_u (.ck_in(ck_pin), .dt_in(dt_pin), .ck_idle(ck_idle), .dt_inv(dt_inv), .respond(respond),
		.bits(bits), .tx_word(tx_word), .ck_out(p_ck), .ck_oe(p_ck_oe), .dt_out(p_dt), .dt_oe(p_dt_oe),
		.rx_word(p_rx));
	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	always @(posedge ck_pin)
		rise_cnt++;
	// Hang guard, well above the expected run length
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 8000)
		begin
			n_fail++;
			results();
		end
	end
	task automatic results();
		if (n_fail == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(posedge clk);
		d = rdata;
	endtask
	task automatic chk_reg(input string what, input logic [2:0] a, input logic [7:0] mask, input logic [7:0] exp);
		logic [7:0] d;
		rd_reg(a, d);
		check(what, {1'b0, d & mask}, {1'b0, exp});
	endtask
	// Polls the receive flag; polling reads leave it set
	task automatic wait_rx();
		logic [7:0] d;
		int i;
		d = 8'h00;
		for (i = 0; i < 400 && d[IRQ_RCIF] !== 1'b1; i++)
			rd_reg(OFS_IRQ, d);
		check("receive flag", {8'h00, d[IRQ_RCIF]}, 9'h001);
	endtask
	initial
	begin
		int i, r0;
		rst = 1'b1;
		addr = 3'h0;
		wdata = 8'h00;
		wr = 1'b0;
		rd = 1'b0;
		sleep_mode = 1'b0;
		ck_idle = 1'b0;
		dt_inv = 1'b0;
		respond = 1'b0;
		bits = 4'h8;
		tx_word = 9'h000;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		for (i = 0; i < 8; i++)
			chk_reg("reset value", 3'(i), 8'hff, rst_val[i]);
		wr_reg(OFS_RDB, 8'ha5);
		wr_reg(OFS_DIVH, 8'h5c);
		wr_reg(OFS_RSC, 8'h0c);
		chk_reg("receive buffer read only", OFS_RDB, 8'hff, 8'h00);
		chk_reg("divisor high", OFS_DIVH, 8'hff, 8'h5c);
		chk_reg("unused status bits", OFS_RSC, 8'hff, 8'h00);
		// Single-word master reception
		wr_reg(OFS_DIVL, 8'h04);
		wr_reg(OFS_TSC, 8'h90);
		wr_reg(OFS_IRQ, 8'h01);
		wr_reg(OFS_RSC, 8'h80);
		tx_word <= 9'h05a;
		respond <= 1'b1;
		r0 = rise_cnt;
		wr_reg(OFS_RSC, 8'ha0);
		wait_rx();
		check("receive irq", {8'h00, rx_irq}, 9'h001);
		chk_reg("single enable", OFS_RSC, 8'hff, 8'h80);
		chk_reg("single word", OFS_RDB, 8'hff, 8'h5a);
		repeat (60) @(posedge clk);
		check("clock pulses", 9'(rise_cnt - r0), 9'h008);
		check("receive irq cleared", {8'h00, rx_irq}, 9'h000);
		// Inverted polarity, nine bits, both enables set
		wr_reg(OFS_RSC, 8'h00);
		wr_reg(OFS_IRQ, 8'h00);
		wr_reg(OFS_BAUD, 8'h30);
		ck_idle <= 1'b1;
		dt_inv <= 1'b1;
		bits <= 4'h9;
		tx_word <= 9'h1c3;
		wr_reg(OFS_RSC, 8'hc0);
		repeat (3) @(posedge clk);
		check("clock idle", {7'h00, ck_oe, ck_o}, 9'h003);
		check("data idle", {8'h00, dt_o}, 9'h001);
		wr_reg(OFS_RSC, 8'hf0);
		for (i = 0; i < 2; i++)
		begin
			wait_rx();
			check("masked receive irq", {8'h00, rx_irq}, 9'h000);
			chk_reg("ninth bit", OFS_RSC, 8'h01, 8'h01);
			chk_reg("continuous word", OFS_RDB, 8'hff, 8'hc3);
		end
		// Unread words force an overrun
		repeat (250) @(posedge clk);
		chk_reg("overrun", OFS_RSC, 8'h02, 8'h02);
		wr_reg(OFS_RSC, 8'hc0);
		chk_reg("errors cleared", OFS_RSC, 8'hfe, 8'hc0);
		chk_reg("kept word", OFS_RDB, 8'hff, 8'hc3);
		respond <= 1'b0;
		// Wide divisor: the clock may leave idle only after 257 counts
		wr_reg(OFS_DIVH, 8'h01);
		wr_reg(OFS_DIVL, 8'h00);
		wr_reg(OFS_BAUD, 8'h38);
		r0 = rise_cnt;
		wr_reg(OFS_RSC, 8'ha0);
		repeat (300) @(posedge clk);
		check("wide divisor edges", 9'(rise_cnt - r0), 9'h000);
		check("wide divisor clock", {8'h00, ck_o}, 9'h000);
		// Slave transmission across sleep
		wr_reg(OFS_RSC, 8'h00);
		wr_reg(OFS_BAUD, 8'h00);
		ck_idle <= 1'b0;
		dt_inv <= 1'b0;
		wr_reg(OFS_TSC, 8'h30);
		wr_reg(OFS_IRQ, 8'h02);
		wr_reg(OFS_RSC, 8'h80);
		check("clock pin released", {8'h00, ck_oe}, 9'h000);
		wr_reg(OFS_TDB, 8'h3c);
		wr_reg(OFS_TDB, 8'h96);
		sleep_mode <= 1'b1;
		repeat (4) @(posedge clk);
		check("empty irq held", {7'h00, tx_irq, wake_req}, 9'h000);
		chk_reg("empty flag held", OFS_IRQ, 8'h08, 8'h00);
		peer_u.clock_bits(8);
		check("first word", {1'b0, p_rx[8:1]}, 9'h03c);
		repeat (6) @(posedge clk);
		check("empty irq and wake", {7'h00, tx_irq, wake_req}, 9'h003);
		peer_u.clock_bits(8);
		check("second word", {1'b0, p_rx[8:1]}, 9'h096);
		wr_reg(OFS_IRQ, 8'h02);
		chk_reg("empty flag kept", OFS_IRQ, 8'h0a, 8'h0a);
		wr_reg(OFS_TSC, 8'h10);
		wr_reg(OFS_TDB, 8'h11);
		chk_reg("empty flag cleared by write", OFS_IRQ, 8'h08, 8'h00);
		results();
	end
endmodule
